// ---- tmcar_pkg.sv ----
// tmcar_pkg: command codes, field positions, reset values and timing for the config/alarm block
package tmcar_pkg;

  // ----------------------------------------------------------------
  // command byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OPCTRL = 8'h41;
  localparam logic [7:0] CMD_ALMASK = 8'h42;
  localparam logic [7:0] CMD_OTMASK = 8'h43;
  localparam logic [7:0] CMD_ALSTAT = 8'h44;
  localparam logic [7:0] CMD_OTSTAT = 8'h45;

  // ----------------------------------------------------------------
  // operating_control fields
  // ----------------------------------------------------------------
  localparam int OPC_STANDBY_BIT = 7;
  localparam int OPC_SOFTRST_BIT = 6;
  localparam int OPC_TMO_DIS_BIT = 5;
  localparam int OPC_FAST1_BIT = 4;
  localparam int OPC_RCANCEL_BIT = 3;
  localparam logic [7:0] OPC_WR_MASK = 8'hb8;

  // ----------------------------------------------------------------
  // mask / status layouts
  // ----------------------------------------------------------------
  localparam int NUM_ALERT_CH = 7;
  localparam int LOCAL_CH_BIT = 6;
  localparam int NUM_OT_CH = 4;
  localparam logic [7:0] ALMASK_WR_MASK = 8'h7f;
  localparam logic [7:0] OTMASK_WR_MASK = 8'h39;
  localparam int OT_CH1_BIT = 0;
  localparam int OT_CH4_BIT = 3;
  localparam int OT_CH5_BIT = 4;
  localparam int OT_CH6_BIT = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPCTRL_RST = 8'h00;
  localparam logic [7:0] ALMASK_RST = 8'h00;
  localparam logic [7:0] OTMASK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------
  // thermal and timing constants
  // ----------------------------------------------------------------
  localparam logic [8:0] OT_HYST_DEGC = 9'h004;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RCANCEL_EXTRA_MS = 125;
  localparam int unsigned RCANCEL_EXTRA_CYC = RCANCEL_EXTRA_MS * (CLK_HZ / 1000);

endpackage

// ---- tmcar_alarm_if.sv ----
// tmcar_alarm_if: signals between the register front end and the alarm engine
interface tmcar_alarm_if;
  import tmcar_pkg::*;
  logic soft_rst;
  logic conv_done;
  logic [NUM_ALERT_CH-1:0][7:0] temp;
  logic [NUM_ALERT_CH-1:0][7:0] alert_limit;
  logic [NUM_OT_CH-1:0][7:0] ot_limit;
  logic [7:0] alert_mask;
  logic [7:0] ot_mask;
  logic alert_stat_rd;
  logic ara_ack;
  logic ot_stat_rd;
  logic [7:0] alert_status;
  logic [7:0] ot_status;
  logic alert_active;
  logic ot_active;

  modport front (output soft_rst, conv_done, temp, alert_limit, ot_limit, alert_mask, ot_mask,
                 alert_stat_rd, ara_ack, ot_stat_rd,
                 input alert_status, ot_status, alert_active, ot_active);
  modport engine (input soft_rst, conv_done, temp, alert_limit, ot_limit, alert_mask, ot_mask,
                  alert_stat_rd, ara_ack, ot_stat_rd,
                  output alert_status, ot_status, alert_active, ot_active);
endinterface

// ---- tmcar_alarm.sv ----
// tmcar_alarm: alert and overtemperature status flags, hysteresis and output state
module tmcar_alarm (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // link to register front end
  tmcar_alarm_if.engine alm
);
  import tmcar_pkg::*;

  // ----------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------
  function automatic logic above(input logic [7:0] t, input logic [7:0] lim);
    above = t > lim;
  endfunction

  // condition leaves only once temp + hyst < limit; 9 bits avoid wrap near 255
  function automatic logic below_hyst(input logic [7:0] t, input logic [7:0] lim);
    below_hyst = ({1'b0, t} + OT_HYST_DEGC) < {1'b0, lim};
  endfunction

  logic [NUM_OT_CH-1:0] ot_cond_q;
  logic [NUM_ALERT_CH-1:0] al_hit;
  logic [NUM_OT_CH-1:0] ot_hit;
  logic [NUM_OT_CH-1:0] ot_msk;
  logic [NUM_OT_CH-1:0] ot_cond_d;
  logic [7:0] ot_hit8;
  logic [NUM_OT_CH-1:0][7:0] ot_temp;

  assign ot_temp = {alm.temp[5], alm.temp[4], alm.temp[3], alm.temp[0]};
  assign ot_msk = {alm.ot_mask[OT_CH6_BIT], alm.ot_mask[OT_CH5_BIT],
                   alm.ot_mask[OT_CH4_BIT], alm.ot_mask[OT_CH1_BIT]};

  always_comb begin
    for (int i = 0; i < NUM_ALERT_CH; i++) begin
      al_hit[i] = above(alm.temp[i], alm.alert_limit[i]);
    end
    for (int j = 0; j < NUM_OT_CH; j++) begin
      ot_hit[j] = above(ot_temp[j], alm.ot_limit[j]);
      ot_cond_d[j] = ot_cond_q[j];
      if (ot_hit[j]) begin
        ot_cond_d[j] = 1'b1;
      end else if (below_hyst(ot_temp[j], alm.ot_limit[j])) begin
        ot_cond_d[j] = 1'b0;
      end
    end
    ot_hit8 = 8'h00;
    ot_hit8[OT_CH1_BIT] = ot_hit[0];
    ot_hit8[OT_CH4_BIT] = ot_hit[1];
    ot_hit8[OT_CH5_BIT] = ot_hit[2];
    ot_hit8[OT_CH6_BIT] = ot_hit[3];
  end

  // ----------------------------------------------------------------
  // alert status and output
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alm.alert_status <= STATUS_RST;
    end else if (alm.soft_rst) begin
      alm.alert_status <= STATUS_RST;
    end else if (alm.conv_done) begin
      // masked channels still flag; a read in this cycle loses to the set
      alm.alert_status <= alm.alert_status | {1'b0, al_hit};
    end else if (alm.alert_stat_rd) begin
      alm.alert_status <= STATUS_RST;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alm.alert_active <= 1'b0;
    end else if (alm.soft_rst) begin
      alm.alert_active <= 1'b0;
    end else if (alm.conv_done && |(al_hit & ~alm.alert_mask[NUM_ALERT_CH-1:0])) begin
      alm.alert_active <= 1'b1;
    end else if (alm.alert_stat_rd || alm.ara_ack) begin
      alm.alert_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // overtemperature status, condition and output
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alm.ot_status <= STATUS_RST;
    end else if (alm.soft_rst) begin
      alm.ot_status <= STATUS_RST;
    end else if (alm.conv_done) begin
      alm.ot_status <= alm.ot_status | ot_hit8;
    end else if (alm.ot_stat_rd) begin
      alm.ot_status <= STATUS_RST;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ot_cond_q <= '0;
    end else if (alm.soft_rst) begin
      ot_cond_q <= '0;
    end else if (alm.conv_done) begin
      ot_cond_q <= ot_cond_d;
    end
  end

  // status reads never touch this; only the masked hysteresis condition and soft reset do
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alm.ot_active <= 1'b0;
    end else if (alm.soft_rst) begin
      alm.ot_active <= 1'b0;
    end else if (alm.conv_done) begin
      alm.ot_active <= |(ot_cond_d & ~ot_msk);
    end
  end

endmodule

// ---- tmcar_top.sv ----
// tmcar_top: configuration registers, command-byte access and alarm outputs of the monitor
module tmcar_top #(
  parameter int unsigned RCANCEL_CYC = tmcar_pkg::RCANCEL_EXTRA_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // command-byte register access from the serial bus engine
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_cmd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic ara_ack_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // measurement sequencer
  input wire logic conv_done_i,
  input wire logic ch1_conv_start_i,
  input wire logic [tmcar_pkg::NUM_ALERT_CH-1:0][7:0] temp_i,
  input wire logic [tmcar_pkg::NUM_ALERT_CH-1:0][7:0] alert_limit_i,
  input wire logic [tmcar_pkg::NUM_OT_CH-1:0][7:0] ot_limit_i,
  output logic standby_o,
  output logic bus_timeout_en_o,
  output logic ch1_fast_conv_o,
  output logic ch1_rcancel_o,
  output logic ch1_extend_busy_o,
  // open-drain alarm pins, active low on the wire
  output logic alert_pin_o,
  output logic alert_pin_oe_n_o,
  output logic overtemp_out_pin_o,
  output logic overtemp_out_oe_n_o
);
  import tmcar_pkg::*;

  localparam int CNT_W = (RCANCEL_CYC > 1) ? $clog2(RCANCEL_CYC + 1) : 1;

  tmcar_alarm_if alm ();

  logic [7:0] opctrl_q;
  logic [7:0] almask_q;
  logic [7:0] otmask_q;
  logic soft_rst_q;
  logic [CNT_W-1:0] ext_cnt_q;
  logic wr_opctrl;
  logic rd_hit_al;
  logic rd_hit_ot;
  logic [7:0] rd_mux;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign wr_opctrl = reg_wr_i && (reg_cmd_i == CMD_OPCTRL);
  assign rd_hit_al = reg_rd_i && (reg_cmd_i == CMD_ALSTAT);
  assign rd_hit_ot = reg_rd_i && (reg_cmd_i == CMD_OTSTAT);

  // ----------------------------------------------------------------
  // soft reset strobe
  // ----------------------------------------------------------------
  // one cycle after the write; the bit itself is never stored, so it reads 0
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_opctrl && reg_wdata_i[OPC_SOFTRST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opctrl_q <= OPCTRL_RST;
    end else if (soft_rst_q) begin
      opctrl_q <= OPCTRL_RST;
    end else if (wr_opctrl && !reg_wdata_i[OPC_SOFTRST_BIT]) begin
      opctrl_q <= reg_wdata_i & OPC_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      almask_q <= ALMASK_RST;
    end else if (soft_rst_q) begin
      almask_q <= ALMASK_RST;
    end else if (reg_wr_i && reg_cmd_i == CMD_ALMASK) begin
      almask_q <= reg_wdata_i & ALMASK_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      otmask_q <= OTMASK_RST;
    end else if (soft_rst_q) begin
      otmask_q <= OTMASK_RST;
    end else if (reg_wr_i && reg_cmd_i == CMD_OTMASK) begin
      otmask_q <= reg_wdata_i & OTMASK_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign standby_o = opctrl_q[OPC_STANDBY_BIT];
  assign bus_timeout_en_o = ~opctrl_q[OPC_TMO_DIS_BIT];
  assign ch1_fast_conv_o = opctrl_q[OPC_FAST1_BIT];
  assign ch1_rcancel_o = opctrl_q[OPC_RCANCEL_BIT];

  // ----------------------------------------------------------------
  // channel 1 conversion extension
  // ----------------------------------------------------------------
  // sequencer holds channel 1 open while busy; restart on a new start
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_cnt_q <= '0;
    end else if (soft_rst_q || standby_o) begin
      ext_cnt_q <= '0;
    end else if (ch1_conv_start_i && opctrl_q[OPC_RCANCEL_BIT]) begin
      ext_cnt_q <= CNT_W'(RCANCEL_CYC);
    end else if (ext_cnt_q != '0) begin
      ext_cnt_q <= ext_cnt_q - CNT_W'(1);
    end
  end

  assign ch1_extend_busy_o = (ext_cnt_q != '0);

  // ----------------------------------------------------------------
  // alarm engine
  // ----------------------------------------------------------------
  // conversions are ignored in standby so no flag is set; reads still clear them and ara_ack still releases the alert output
  assign alm.soft_rst = soft_rst_q;
  assign alm.conv_done = conv_done_i && !standby_o;
  assign alm.temp = temp_i;
  assign alm.alert_limit = alert_limit_i;
  assign alm.ot_limit = ot_limit_i;
  assign alm.alert_mask = almask_q;
  assign alm.ot_mask = otmask_q;
  assign alm.alert_stat_rd = rd_hit_al;
  assign alm.ara_ack = ara_ack_i;
  assign alm.ot_stat_rd = rd_hit_ot;

  tmcar_alarm u_alarm (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .alm(alm.engine)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_cmd_i)
      CMD_OPCTRL: rd_mux = opctrl_q;
      CMD_ALMASK: rd_mux = almask_q;
      CMD_OTMASK: rd_mux = otmask_q;
      CMD_ALSTAT: rd_mux = alm.alert_status;
      CMD_OTSTAT: rd_mux = alm.ot_status;
      default: rd_mux = UNMAPPED_RD;
    endcase
  end

  // data sampled before the read's clear takes effect
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain pins
  // ----------------------------------------------------------------
  assign alert_pin_o = 1'b0;
  assign alert_pin_oe_n_o = ~alm.alert_active;
  assign overtemp_out_pin_o = 1'b0;
  assign overtemp_out_oe_n_o = ~alm.ot_active;

endmodule

// ---- tmcar_top_asserts.sv ----
// tmcar_top_asserts: port-level checks of config decode and alarm outputs
module tmcar_top_asserts import tmcar_pkg::*; #(
  parameter int unsigned RCANCEL_CYC = RCANCEL_EXTRA_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // inputs of the block
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_cmd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic ara_ack_i,
  input wire logic conv_done_i,
  input wire logic ch1_conv_start_i,
  // outputs of the block
  input wire logic standby_o,
  input wire logic bus_timeout_en_o,
  input wire logic ch1_fast_conv_o,
  input wire logic ch1_rcancel_o,
  input wire logic ch1_extend_busy_o,
  input wire logic alert_pin_oe_n_o,
  input wire logic overtemp_out_oe_n_o
);
  logic cfg_wr, cfg_ok, sr_q;
  logic [7:0] wd_q;
  logic [31:0] cnt_q;
  assign cfg_wr = reg_wr_i && reg_cmd_i == CMD_OPCTRL;
  // writes in the soft reset cycle are overridden, so they are not judged
  assign cfg_ok = cfg_wr && !reg_wdata_i[OPC_SOFTRST_BIT] && !sr_q;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sr_q <= 1'b0;
      wd_q <= 8'h00;
    end else begin
      sr_q <= cfg_wr && reg_wdata_i[OPC_SOFTRST_BIT];
      wd_q <= reg_wdata_i;
    end
  end
  // reference count of the extension, cleared by standby and soft reset
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 32'h0;
    end else if (standby_o || sr_q) begin
      cnt_q <= 32'h0;
    end else if (ch1_conv_start_i && ch1_rcancel_o) begin
      cnt_q <= RCANCEL_CYC;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_standby; cfg_ok |=> standby_o == wd_q[OPC_STANDBY_BIT]; endproperty
  a_standby: assert property (p_standby) else $error("standby bad");
  property p_tmo; cfg_ok |=> bus_timeout_en_o != wd_q[OPC_TMO_DIS_BIT]; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout enable bad");
  property p_ch1;
    cfg_ok |=> {ch1_fast_conv_o, ch1_rcancel_o} == {wd_q[OPC_FAST1_BIT], wd_q[OPC_RCANCEL_BIT]};
  endproperty
  a_ch1: assert property (p_ch1) else $error("ch1 config bad");
  property p_srst;
    cfg_wr && reg_wdata_i[OPC_SOFTRST_BIT] |-> ##2 !standby_o && bus_timeout_en_o && !ch1_rcancel_o && !ch1_fast_conv_o
      && !ch1_extend_busy_o && alert_pin_oe_n_o && overtemp_out_oe_n_o;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset incomplete");
  property p_ext; ch1_extend_busy_o == (cnt_q != 32'h0); endproperty
  a_ext: assert property (p_ext) else $error("extension length bad");
  property p_alclr; reg_rd_i && reg_cmd_i == CMD_ALSTAT && !conv_done_i |=> alert_pin_oe_n_o; endproperty
  a_alclr: assert property (p_alclr) else $error("alert not cleared by read");
  property p_ara; ara_ack_i && !conv_done_i |=> alert_pin_oe_n_o; endproperty
  a_ara: assert property (p_ara) else $error("alert not cleared by response");
  property p_alset; $fell(alert_pin_oe_n_o) |-> $past(conv_done_i) && !$past(standby_o); endproperty
  a_alset: assert property (p_alset) else $error("alert set outside conversion");
  property p_otkeep;
    reg_rd_i && reg_cmd_i == CMD_OTSTAT && !conv_done_i && !sr_q |=> $stable(overtemp_out_oe_n_o);
  endproperty
  a_otkeep: assert property (p_otkeep) else $error("overtemp changed by read");
  property p_otwhen; $changed(overtemp_out_oe_n_o) |-> $past(conv_done_i) || $past(sr_q); endproperty
  a_otwhen: assert property (p_otwhen) else $error("overtemp changed outside conversion");
endmodule

bind tmcar_top tmcar_top_asserts #(.RCANCEL_CYC(RCANCEL_CYC)) u_asserts (
  .sys_clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_cmd_i, .reg_wdata_i, .ara_ack_i, .conv_done_i,
  .ch1_conv_start_i, .standby_o, .bus_timeout_en_o, .ch1_fast_conv_o, .ch1_rcancel_o, .ch1_extend_busy_o,
  .alert_pin_oe_n_o, .overtemp_out_oe_n_o
);

// ---- tmcar_host.sv ----
// tmcar_host: command-byte host model issuing register reads and writes
module tmcar_host (
  // clock
  input wire logic sys_clk_i,
  // register access
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_cmd_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_cmd_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge sys_clk_i);
    reg_cmd_o = cmd;
    reg_wdata_o = data;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    // released lines flip so stale values never look live
    reg_cmd_o = ~cmd;
    reg_wdata_o = ~data;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
    @(negedge sys_clk_i);
    reg_cmd_o = cmd;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_cmd_o = ~cmd;
    // a missing answer strobe turns into unknown data
    data = reg_rvalid_i ? reg_rdata_i : 8'hxx;
  endtask
endmodule

// ---- testbench.sv ----
// testbench: directed checks of config registers and alarm outputs
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tmcar_pkg::*;
  logic sys_clk_i, sys_rst_i, wr, rd, ara, conv, start, rvalid;
  logic stby, tmo_en, fast, rcan, busy, al_oe_n, ot_oe_n, al_pin, ot_pin;
  logic [7:0] cmd, wdata, rdata, v;
  logic [NUM_ALERT_CH-1:0][7:0] temp, alim;
  logic [NUM_OT_CH-1:0][7:0] olim;
  logic [7:0] cmds [6] = '{CMD_OPCTRL, CMD_ALMASK, CMD_OTMASK, CMD_ALSTAT, CMD_OTSTAT, 8'h46};
  int otb [4] = '{0, 3, 4, 5};
  int fail_count, comparisons, n, b;
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  tmcar_top #(.RCANCEL_CYC(10)) DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_cmd_i(cmd), .reg_wdata_i(wdata), .ara_ack_i(ara), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .conv_done_i(conv), .ch1_conv_start_i(start), .temp_i(temp),
    .alert_limit_i(alim), .ot_limit_i(olim), .standby_o(stby), .bus_timeout_en_o(tmo_en),
    .ch1_fast_conv_o(fast), .ch1_rcancel_o(rcan), .ch1_extend_busy_o(busy), .alert_pin_o(al_pin),
    .alert_pin_oe_n_o(al_oe_n), .overtemp_out_pin_o(ot_pin), .overtemp_out_oe_n_o(ot_oe_n));
  tmcar_host host (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_cmd_o(cmd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(input int which);
    @(negedge sys_clk_i);
    if (which == 0) conv = 1'b1;
    else if (which == 1) ara = 1'b1;
    else start = 1'b1;
    @(negedge sys_clk_i);
    conv = 1'b0;
    ara = 1'b0;
    start = 1'b0;
  endtask
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    sys_rst_i = 1'b1;
    {conv, ara, start} = 3'h0;
    temp = {NUM_ALERT_CH{8'h40}};
    alim = {NUM_ALERT_CH{8'h50}};
    olim = {NUM_OT_CH{8'h50}};
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    foreach (cmds[i]) begin
      host.rd(cmds[i], v);
      chk("reset value", v, 8'h00);
    end
    chk("timeout enable", tmo_en, 1'b1);
    host.wr(CMD_OPCTRL, 8'hbf);
    host.wr(CMD_ALMASK, 8'hff);
    host.wr(CMD_OTMASK, 8'hff);
    host.wr(CMD_ALSTAT, 8'hff);
    host.rd(CMD_OPCTRL, v);
    chk("opctrl", v, 8'hb8);
    chk("standby", stby, 1'b1);
    chk("timeout enable", tmo_en, 1'b0);
    chk("fast ch1", fast, 1'b1);
    chk("rcancel", rcan, 1'b1);
    host.rd(CMD_ALMASK, v);
    chk("alert mask", v, 8'h7f);
    host.rd(CMD_OTMASK, v);
    chk("ot mask", v, 8'h39);
    temp = {NUM_ALERT_CH{8'h60}};
    pulse(0);
    host.rd(CMD_ALSTAT, v);
    chk("standby status", v, 8'h00);
    temp = {NUM_ALERT_CH{8'h40}};
    host.wr(CMD_OPCTRL, 8'h40);
    host.rd(CMD_OPCTRL, v);
    chk("soft reset opctrl", v, 8'h00);
    host.rd(CMD_ALMASK, v);
    chk("soft reset mask", v, 8'h00);
    host.rd(CMD_OTMASK, v);
    chk("soft reset ot mask", v, 8'h00);
    chk("soft reset standby", stby, 1'b0);
    host.wr(CMD_OPCTRL, 8'h08);
    pulse(2);
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk_i);
    end
    chk("extension cycles", n[7:0], 8'h0a);
    host.wr(CMD_OPCTRL, 8'h00);
    temp[0] = 8'h60;
    pulse(0);
    chk("alert set", al_oe_n, 1'b0);
    chk("alert pin data", al_pin, 1'b0);
    host.rd(CMD_ALSTAT, v);
    chk("alert status", v, 8'h01);
    chk("alert read clear", al_oe_n, 1'b1);
    pulse(0);
    chk("alert again", al_oe_n, 1'b0);
    pulse(1);
    chk("response clear", al_oe_n, 1'b1);
    host.rd(CMD_ALSTAT, v);
    chk("status kept", v, 8'h01);
    host.rd(CMD_ALSTAT, v);
    chk("status cleared", v, 8'h00);
    temp[0] = 8'h40;
    for (int i = 0; i < NUM_ALERT_CH; i++) begin
      host.wr(CMD_ALMASK, 8'h01 << i);
      temp[i] = 8'h60;
      pulse(0);
      chk("alert masked", al_oe_n, 1'b1);
      host.rd(CMD_ALSTAT, v);
      chk("masked status", v, 8'h01 << i);
      temp[i] = 8'h40;
    end
    host.wr(CMD_ALMASK, 8'h00);
    pulse(0);
    host.rd(CMD_OTSTAT, v);
    for (int k = 0; k < NUM_OT_CH; k++) begin
      b = otb[k];
      temp[b] = 8'h60;
      pulse(0);
      chk("ot out", ot_oe_n, 1'b0);
      chk("ot pin data", ot_pin, 1'b0);
      host.rd(CMD_OTSTAT, v);
      chk("ot status", v, 8'h01 << b);
      chk("ot kept", ot_oe_n, 1'b0);
      host.rd(CMD_OTSTAT, v);
      chk("ot cleared", v, 8'h00);
      host.wr(CMD_OTMASK, 8'h01 << b);
      pulse(0);
      chk("ot masked", ot_oe_n, 1'b1);
      host.rd(CMD_OTSTAT, v);
      chk("ot masked status", v, 8'h01 << b);
      host.wr(CMD_OTMASK, 8'h00);
      temp[b] = 8'h40;
      pulse(0);
    end
    temp[0] = 8'h60;
    pulse(0);
    // 76 + 4 is not below 80, so the condition must hold
    temp[0] = 8'h4c;
    pulse(0);
    chk("ot hold", ot_oe_n, 1'b0);
    olim[0] = 8'h51;
    pulse(0);
    chk("ot released", ot_oe_n, 1'b1);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    summarize();
  end
endmodule
